// >>> hdl/drsf_regs.svh
/*
 * constants for the result-phase fault and drive sense bytes.
 * assumes inclusion by bare name from the design file.
 */
`ifndef DRSF_REGS_SVH
`define DRSF_REGS_SVH
`define DRSF_A_END_CYL 7
`define DRSF_A_CRC_ANY 5
`define DRSF_A_OVERRUN 4
`define DRSF_A_SECT_MISS 2
`define DRSF_A_WR_BLOCK 1
`define DRSF_A_HDR_SYNC 0
`define DRSF_B_WRONG_MARK 6
`define DRSF_B_DATA_CRC 5
`define DRSF_B_CYL_MISM 4
`define DRSF_B_BAD_CYL 1
`define DRSF_B_DATA_SYNC 0
`define DRSF_S_WR_PROT 6
`define DRSF_S_ONE_HI 5
`define DRSF_S_TRK_ZERO 4
`define DRSF_S_ONE_LO 3
`define DRSF_S_HEAD 2
`define DRSF_LAST_SECTOR 8'hff
`define DRSF_BAD_TRACK 8'hff
`define DRSF_BYTE_ZERO 8'h00
`define DRSF_SEL_A 2'h0
`define DRSF_SEL_B 2'h1
`define DRSF_SEL_S 2'h2
`endif

// >>> hdl/drsf_pkg.sv
/*
 * types for the result-phase status block.
 * assumes nothing of its surroundings.
 */
package drsf_pkg;
    typedef enum logic [2:0] {
        DRSF_IDLE = 3'b001,
        DRSF_EXEC = 3'b010,
        DRSF_DONE = 3'b100
    } drsf_state_t;
    typedef enum logic [1:0] {
        DRSF_CMD_OTHER = 2'h0,
        DRSF_CMD_FETCH = 2'h1,
        DRSF_CMD_STORE = 2'h2,
        DRSF_CMD_LAYOUT = 2'h3
    } drsf_cmd_t;
endpackage : drsf_pkg

// >>> hdl/drsf_status.sv
/*
 * assembles the second, third and fourth result bytes of a disk controller.
 * assumes the sequencer pulses events on core_clk, drive pins are asynchronous.
 */
`timescale 1ns/1ps
`include "drsf_regs.svh"

module drsf_status (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // mode straps
    input wire logic platform_strap,
    input wire logic encoding_strap,
    output logic platform_mode_q,
    output logic encoding_mode_q,
    // command sequencer
    input wire logic cmd_start,
    input wire drsf_pkg::drsf_cmd_t cmd_kind,
    input wire logic cmd_deleted,
    input wire logic cmd_done,
    input wire logic header_fetch_cmd,
    input wire logic track_fetch_cmd,
    input wire logic terminal_count,
    // disk events
    input wire logic [7:0] sector_number,
    input wire logic sector_step,
    input wire logic header_crc_err,
    input wire logic data_crc_err,
    input wire logic service_miss,
    input wire logic sector_not_found,
    input wire logic header_read_err,
    input wire logic sequence_err,
    input wire logic index_pulse_in,
    input wire logic header_mark_seen,
    input wire logic data_mark_timeout,
    input wire logic data_mark_seen,
    input wire logic data_mark_deleted,
    input wire logic header_valid,
    input wire logic [7:0] header_track,
    input wire logic [7:0] current_cyl,
    // drive pins
    input wire logic write_protect_in,
    input wire logic track_zero_sense,
    input wire logic head_side_out,
    input wire logic [1:0] drive_select_code,
    // result phase read
    input wire logic result_rd,
    input wire logic [1:0] result_sel,
    output logic [7:0] result_data_q,
    output logic result_valid_q
);
    drsf_pkg::drsf_state_t state_q;
    logic [7:0] fault_detail_a_q;
    logic [7:0] fault_detail_b_q;
    logic [1:0] index_count_q;
    logic [1:0] wp_sync_q;
    logic [1:0] tz_sync_q;
    logic wp_prev_q;
    logic strap_pending_q;
    logic [7:0] drive_sense_snapshot;
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic executing;
    logic cyl_differs;
    logic wp_rise;

    assign executing = (state_q == drsf_pkg::DRSF_EXEC);
    assign cyl_differs = header_valid && (header_track != current_cyl);
    assign wp_rise = wp_sync_q[1] && !wp_prev_q;

    // write protect and track zero pins cross into core_clk; head and select are used as they come
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wp_sync_q <= 2'h0;
            tz_sync_q <= 2'h0;
            wp_prev_q <= 1'b0;
        end else if (clk_en) begin
            wp_sync_q <= {wp_sync_q[0], write_protect_in};
            tz_sync_q <= {tz_sync_q[0], track_zero_sense};
            wp_prev_q <= wp_sync_q[1];
        end
    end

    // straps caught on first enabled edge after release
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_pending_q <= 1'b1;
            platform_mode_q <= 1'b0;
            encoding_mode_q <= 1'b0;
        end else if (clk_en && strap_pending_q) begin
            strap_pending_q <= 1'b0;
            platform_mode_q <= platform_strap;
            encoding_mode_q <= encoding_strap;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= drsf_pkg::DRSF_IDLE;
        end else if (clk_en) begin
            unique case (state_q)
                drsf_pkg::DRSF_IDLE: begin
                    if (cmd_start) begin
                        state_q <= drsf_pkg::DRSF_EXEC;
                    end
                end
                drsf_pkg::DRSF_EXEC: begin
                    if (cmd_done) begin
                        state_q <= drsf_pkg::DRSF_DONE;
                    end
                end
                drsf_pkg::DRSF_DONE: begin
                    if (cmd_start) begin
                        state_q <= drsf_pkg::DRSF_EXEC;
                    end
                end
                default: begin
                    state_q <= drsf_pkg::DRSF_IDLE;
                end
            endcase
        end
    end

    // index pulses counted while hunting a header mark
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            index_count_q <= 2'h0;
        end else if (clk_en) begin
            if (cmd_start || header_mark_seen) begin
                index_count_q <= 2'h0;
            end else if (executing && index_pulse_in && index_count_q != 2'h2) begin
                index_count_q <= index_count_q + 2'h1;
            end
        end
    end

    always_comb begin
        set_a = `DRSF_BYTE_ZERO;
        set_b = `DRSF_BYTE_ZERO;
        if (executing) begin
            set_a[`DRSF_A_END_CYL] = (sector_step && sector_number == `DRSF_LAST_SECTOR)
                || (cmd_done && !terminal_count
                && (cmd_kind == drsf_pkg::DRSF_CMD_FETCH
                || cmd_kind == drsf_pkg::DRSF_CMD_STORE));
            set_a[`DRSF_A_CRC_ANY] = header_crc_err || data_crc_err;
            set_a[`DRSF_A_OVERRUN] = service_miss;
            set_a[`DRSF_A_SECT_MISS] = (sector_not_found && cmd_kind == drsf_pkg::DRSF_CMD_FETCH)
                || (header_read_err && header_fetch_cmd)
                || (sequence_err && track_fetch_cmd);
            set_a[`DRSF_A_WR_BLOCK] = wp_rise
                && (cmd_kind == drsf_pkg::DRSF_CMD_STORE
                || cmd_kind == drsf_pkg::DRSF_CMD_LAYOUT);
            set_a[`DRSF_A_HDR_SYNC] = (index_count_q == 2'h2) || data_mark_timeout;
            set_b[`DRSF_B_WRONG_MARK] = data_mark_seen && cmd_kind == drsf_pkg::DRSF_CMD_FETCH
                && (data_mark_deleted != cmd_deleted);
            set_b[`DRSF_B_DATA_CRC] = data_crc_err;
            set_b[`DRSF_B_CYL_MISM] = cyl_differs;
            set_b[`DRSF_B_BAD_CYL] = cyl_differs && header_track == `DRSF_BAD_TRACK;
            set_b[`DRSF_B_DATA_SYNC] = data_mark_timeout;
        end
    end

    // start clears; a same-cycle event lands only when start comes while already executing
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_detail_a_q <= `DRSF_BYTE_ZERO;
        end else if (clk_en) begin
            if (cmd_start) begin
                fault_detail_a_q <= set_a;
            end else begin
                fault_detail_a_q <= fault_detail_a_q | set_a;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_detail_b_q <= `DRSF_BYTE_ZERO;
        end else if (clk_en) begin
            if (cmd_start) begin
                fault_detail_b_q <= set_b;
            end else begin
                fault_detail_b_q <= fault_detail_b_q | set_b;
            end
        end
    end

    always_comb begin
        drive_sense_snapshot = `DRSF_BYTE_ZERO;
        drive_sense_snapshot[`DRSF_S_WR_PROT] = wp_sync_q[1];
        drive_sense_snapshot[`DRSF_S_ONE_HI] = 1'b1;
        drive_sense_snapshot[`DRSF_S_TRK_ZERO] = tz_sync_q[1];
        drive_sense_snapshot[`DRSF_S_ONE_LO] = 1'b1;
        drive_sense_snapshot[`DRSF_S_HEAD] = head_side_out;
        drive_sense_snapshot[1:0] = drive_select_code;
    end

    // bytes leave only through the result read port
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            result_data_q <= `DRSF_BYTE_ZERO;
            result_valid_q <= 1'b0;
        end else if (clk_en) begin
            result_valid_q <= result_rd;
            if (result_rd) begin
                unique case (result_sel)
                    `DRSF_SEL_A: result_data_q <= fault_detail_a_q;
                    `DRSF_SEL_B: result_data_q <= fault_detail_b_q;
                    `DRSF_SEL_S: result_data_q <= drive_sense_snapshot;
                    default: result_data_q <= `DRSF_BYTE_ZERO;
                endcase
            end
        end
    end
endmodule : drsf_status

// >>> bench/drsf_status_properties.sv
/*
 * concurrent checks on the result read port of drsf_status.
 * assumes one clock domain and reads taken on enabled edges.
 */
`timescale 1ns/1ps
module drsf_status_properties (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // drive outputs
    input wire logic head_side_out,
    input wire logic [1:0] drive_select_code,
    // result port
    input wire logic result_rd,
    input wire logic [1:0] result_sel,
    input wire logic [7:0] result_data_q,
    input wire logic result_valid_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_rd_any;
        clk_en && result_rd;
    endsequence
    sequence s_rd(logic [1:0] s);
        clk_en && result_rd && result_sel == s;
    endsequence
    chk_read_valid: assert property (s_rd_any |=> result_valid_q)
        else $error("no result after read");
    chk_valid_pulse: assert property (!(clk_en && result_rd) |=> !result_valid_q)
        else $error("result without read");
    chk_data_hold: assert property (!result_valid_q |-> $stable(result_data_q))
        else $error("result byte moved without read");
    chk_a_unused: assert property (s_rd(2'h0) |=> result_data_q[6] == 1'h0
        && result_data_q[3] == 1'h0) else $error("fault a spare bit set");
    chk_b_unused: assert property (s_rd(2'h1) |=> result_data_q[7] == 1'h0
        && result_data_q[3:2] == 2'h0) else $error("fault b spare bit set");
    chk_snap_fixed: assert property (s_rd(2'h2) |=> result_data_q[7] == 1'h0
        && result_data_q[5] && result_data_q[3]) else $error("snapshot fixed bits wrong");
    chk_snap_head: assert property (s_rd(2'h2) |=> result_data_q[2] == $past(head_side_out))
        else $error("snapshot head bit wrong");
    chk_snap_select: assert property (s_rd(2'h2) |=>
        result_data_q[1:0] == $past(drive_select_code)) else $error("snapshot select wrong");
    chk_bad_cyl: assert property (s_rd(2'h1) |=> !result_data_q[1] || result_data_q[4])
        else $error("bad cylinder without mismatch");
endmodule : drsf_status_properties
bind drsf_status drsf_status_properties chk_u (.core_clk, .reset_n, .clk_en, .head_side_out,
    .drive_select_code, .result_rd, .result_sel, .result_data_q, .result_valid_q);

// >>> bench/drsf_drive_model.sv
/*
 * drive side: protect tab per drive and track zero sensor.
 * assumes the bench sets the tab and sensor levels.
 */
`timescale 1ns/1ps
module drsf_drive_model (
    // from controller and bench
    input wire logic [1:0] drive_select_code,
    input wire logic [3:0] wp_table,
    input wire logic trk_req,
    // sensed pins
    output logic write_protect_in,
    output logic track_zero_sense
);
    // pins settle off the clock grid
    assign #13 write_protect_in = wp_table[drive_select_code];
    assign #13 track_zero_sense = trk_req;
endmodule : drsf_drive_model

// >>> bench/tb_top.sv
/*
 * random and corner commands, then result reads compared to expectations.
 * assumes drsf_status, its checker bind and the drive model.
 */
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'h0, reset_n = 1'h0, platform_strap = 1'h0, encoding_strap = 1'h0;
    logic cmd_start = 1'h0, cmd_deleted = 1'h0, cmd_done = 1'h0, terminal_count = 1'h0;
    logic header_fetch_cmd = 1'h0, track_fetch_cmd = 1'h0, data_mark_deleted = 1'h0;
    logic head_side_out = 1'h0, trk_req = 1'h0, result_rd = 1'h0, clk_en = 1'h1;
    logic [1:0] drive_select_code = 2'h0, result_sel = 2'h0;
    logic [3:0] wp_table = 4'h0;
    logic [10:0] ev = 11'h000;
    logic [7:0] sector_number = 8'h00, header_track = 8'h00, current_cyl = 8'h00;
    logic [7:0] result_data_q;
    logic platform_mode_q, encoding_mode_q, result_valid_q, write_protect_in, track_zero_sense;
    drsf_pkg::drsf_cmd_t cmd_kind = drsf_pkg::DRSF_CMD_OTHER;
    int miscompares = 0, num_checks = 0;
    drsf_status dut_u (.core_clk, .reset_n, .clk_en, .platform_strap, .encoding_strap,
        .platform_mode_q, .encoding_mode_q, .cmd_start, .cmd_kind, .cmd_deleted, .cmd_done,
        .header_fetch_cmd, .track_fetch_cmd, .terminal_count, .sector_number,
        .sector_step(ev[9]), .header_crc_err(ev[0]), .data_crc_err(ev[1]),
        .service_miss(ev[2]), .sector_not_found(ev[3]), .header_read_err(ev[4]),
        .sequence_err(ev[5]), .index_pulse_in(ev[10]), .header_mark_seen(1'h0),
        .data_mark_timeout(ev[6]), .data_mark_seen(ev[7]), .data_mark_deleted,
        .header_valid(ev[8]), .header_track, .current_cyl, .write_protect_in,
        .track_zero_sense, .head_side_out, .drive_select_code, .result_rd, .result_sel,
        .result_data_q, .result_valid_q);
    drsf_drive_model drive_u (.drive_select_code, .wp_table, .trk_req, .write_protect_in,
        .track_zero_sense);
    always #25 core_clk = ~core_clk;
    task tick;
        @(negedge core_clk);
    endtask : tick
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(logic [1:0] s, logic [7:0] e);
        result_rd = 1'h1;
        result_sel = s;
        tick;
        check({7'h00, result_valid_q}, 8'h01);
        check(result_data_q, e);
    endtask : rd
    function automatic logic [15:0] exp_ab(logic [10:0] m, logic [1:0] k, logic t, logic w,
        int n);
        logic [7:0] a, b;
        a = 8'h00;
        b = 8'h00;
        a[7] = (m[9] && sector_number == 8'hff) || ((k == 2'h1 || k == 2'h2) && !t);
        a[5] = m[0] | m[1];
        a[4] = m[2];
        a[2] = (m[3] & (k == 2'h1)) | (m[4] & header_fetch_cmd) | (m[5] & track_fetch_cmd);
        a[1] = w & k[1];
        a[0] = m[6] | (m[10] && n == 2);
        b[6] = m[7] && k == 2'h1 && data_mark_deleted != cmd_deleted;
        b[5] = m[1];
        b[4] = m[8] && header_track != current_cyl;
        b[1] = b[4] && header_track == 8'hff;
        b[0] = m[6];
        return {a, b};
    endfunction : exp_ab
    task automatic rst(logic p, logic e);
        reset_n = 1'h0;
        {platform_strap, encoding_strap} = {p, e};
        repeat (12) tick;
        reset_n = 1'h1;
        repeat (2) tick;
        check({6'h00, platform_mode_q, encoding_mode_q}, {6'h00, p, e});
        rd(2'h0, 8'h00);
        result_rd = 1'h0;
    endtask : rst
    task automatic run(drsf_pkg::drsf_cmd_t k, logic w, logic [10:0] m, int n);
        logic [15:0] e;
        if (m[6]) m[7] = 1'h0;
        {cmd_deleted, header_fetch_cmd, track_fetch_cmd, data_mark_deleted} = 4'($urandom);
        {head_side_out, trk_req, drive_select_code, terminal_count} = 5'($urandom);
        sector_number = ($urandom % 3 == 0) ? 8'hff : 8'($urandom);
        header_track = ($urandom % 3 == 0) ? 8'hff : 8'($urandom);
        current_cyl = ($urandom % 2 == 0) ? header_track : 8'($urandom);
        cmd_kind = k;
        cmd_start = 1'h1;
        tick;
        cmd_start = 1'h0;
        repeat (n) begin
            ev = m;
            if (w) wp_table[drive_select_code] = 1'h1;
            tick;
            ev = 11'h000;
            tick;
        end
        cmd_done = 1'h1;
        tick;
        cmd_done = 1'h0;
        e = exp_ab(m, k, terminal_count, w, n);
        rd(2'h0, e[15:8]);
        rd(2'h1, e[7:0]);
        rd(2'h2, {1'h0, w, 1'h1, trk_req, 1'h1, head_side_out, drive_select_code});
        rd(2'h3, 8'h00);
        result_rd = 1'h0;
        wp_table = 4'h0;
        repeat (3) tick;
    endtask : run
    initial begin
        #1_000_000;
        miscompares++;
        final_report;
    end
    initial begin
        void'($urandom(32'h12e5_fb2a));
        rst(1'h1, 1'h0);
        run(drsf_pkg::DRSF_CMD_STORE, 1'h1, 11'h000, 2);
        run(drsf_pkg::DRSF_CMD_FETCH, 1'h1, 11'h400, 1);
        run(drsf_pkg::DRSF_CMD_LAYOUT, 1'h0, 11'h7ff, 2);
        repeat (40) run(drsf_pkg::drsf_cmd_t'(2'($urandom)), 1'h0, 11'($urandom),
            1 + $urandom % 2);
        rst(1'h0, 1'h1);
        run(drsf_pkg::DRSF_CMD_FETCH, 1'h0, 11'h080, 1);
        // enable low: a read must not be answered
        clk_en = 1'h0;
        result_rd = 1'h1;
        result_sel = 2'h2;
        tick;
        check({7'h00, result_valid_q}, 8'h00);
        check(result_data_q, 8'h00);
        clk_en = 1'h1;
        result_rd = 1'h0;
        tick;
        final_report;
    end
endmodule : tb_top
